// File: scs_clock_select.sv
// system clock select: oscillator enables, divider mux, boot sequencing, avalon register slave
// Operation
// [R1] three oscillators, each with own enable bit
// [R2] both rc oscillators running after boot; code sets only the slow rc enable, fast rc stays off in mode 0xE4
// [R3] fast rc trimmed via trim register, 16MHz
// [R4] 0x34 selects fast rc divided by two
// [R5] 0x14 selects fast rc divided by four
// [R6] 0x3C selects fast rc divided by eight
// [R7] 0x1C selects fast rc divided by sixteen
// [R8] 0x7C selects fast rc divided by 32
// [R9] 0xE4 selects slow rc, fast rc off
// [R10] calibrated boot: watchdog off, slow rc, pin input
// [R11] uncalibrated boot keeps mode, slow or /64
// [R12] uncalibrated boot: watchdog on, slow rc, input
// [R13] calibration runs once, only while programming
// [R14] power-on reset, fast or normal boot time
// [R15] mode write switches clock source immediately
// [R16] software disables old oscillator only later
// [R17] crystal drive 01 low, 10 mid, 11 high
// [R18] source and divider change without glitches
`timescale 1ns/1ps
module scs_clock_select #(
	parameter int BOOT_FAST_CYC = scs_pkg::SCS_BOOT_FAST_CYC,
	parameter int BOOT_NORM_CYC = scs_pkg::SCS_BOOT_NORM_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic fast_internal_rc_osc_i,
	input wire logic slow_internal_rc_osc_i,
	input wire logic external_crystal_osc_i,
	input wire logic boot_fast_i,
	input wire logic [2:0] calibration_directive_i,
	input wire logic prog_mode_i,
	output logic sys_clk_o,
	output logic sys_tick_o,
	output logic fast_rc_en_o,
	output logic slow_rc_en_o,
	output logic xtal_en_o,
	output logic [1:0] xtal_drive_o,
	output logic [7:0] fast_rc_trim_o,
	output logic wdt_en_o,
	output logic port_a_bit_five_input_o,
	output logic boot_done_o,
	output logic cal_run_o
);
	typedef enum {ST_CAPTURE, ST_BOOT, ST_RUN} scs_state_t;

	logic [scs_pkg::SCS_SYNC_W-1:0] pin_sync;
	logic [2:0] osc_d_reg;
	logic [2:0] osc_rise;
	logic [2:0] osc_fall;

	scs_sync #(
		.WIDTH(scs_pkg::SCS_SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.async_i({prog_mode_i, calibration_directive_i, boot_fast_i,
			external_crystal_osc_i, slow_internal_rc_osc_i, fast_internal_rc_osc_i}),
		.sync_o(pin_sync)
	);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			osc_d_reg <= '0;
		end else begin
			osc_d_reg <= pin_sync[scs_pkg::SCS_PIN_XTAL:scs_pkg::SCS_PIN_FAST];
		end
	end
	assign osc_rise = pin_sync[scs_pkg::SCS_PIN_XTAL:scs_pkg::SCS_PIN_FAST] & ~osc_d_reg;
	assign osc_fall = ~pin_sync[scs_pkg::SCS_PIN_XTAL:scs_pkg::SCS_PIN_FAST] & osc_d_reg;

	// bus handshake: every access waits exactly one cycle
	logic wait_reg;
	logic wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic bus_req;
	logic wr_take;
	logic [5:0] bus_idx;

	assign bus_req = avs_read_i || avs_write_i;
	assign bus_idx = avs_address_i[7:2];
	assign wr_take = avs_write_i && !wait_reg && avs_byteenable_i[0];

	// control state
	scs_state_t state_reg;
	scs_state_t state_next;
	logic [scs_pkg::SCS_BOOT_CNT_W-1:0] boot_cnt_reg;
	logic [scs_pkg::SCS_BOOT_CNT_W-1:0] boot_cnt_next;
	logic [2:0] cal_opt_reg;
	logic [2:0] cal_opt_next;
	logic prog_reg;
	logic prog_next;
	logic [7:0] clkmd_reg;
	logic [7:0] clkmd_next;
	logic [7:0] eoscr_reg;
	logic [7:0] eoscr_next;
	logic [7:0] ihrcr_reg;
	logic [7:0] ihrcr_next;
	logic wdt_reg;
	logic wdt_next;
	logic pin_in_reg;
	logic pin_in_next;
	logic cal_run_reg;
	logic cal_run_next;
	logic cal_ran_reg;
	logic cal_ran_next;
	logic mode_load;
	logic boot_done_reg;
	logic boot_done_next;

	// clock generation state
	scs_pkg::scs_src_t src_reg;
	scs_pkg::scs_src_t src_next;
	logic [5:0] half_reg;
	logic [5:0] half_next;
	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;
	logic sys_clk_reg;
	logic sys_clk_next;
	logic sys_tick_reg;
	logic sys_tick_next;
	logic src_tick;
	localparam logic [5:0] SCS_ONE = 6'h01;
	localparam logic [scs_pkg::SCS_BOOT_CNT_W-1:0] SCS_STRAP_SETTLE = 24'h000002;

	always_comb begin
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		if (bus_req && wait_reg) begin
			wait_next = 1'b0;
			rdata_next = '0;
			unique case (bus_idx)
				scs_pkg::SCS_IDX_CLKMD: rdata_next[7:0] = clkmd_reg;
				scs_pkg::SCS_IDX_IHRCR: rdata_next[7:0] = ihrcr_reg;
				scs_pkg::SCS_IDX_EOSCR: rdata_next[7:0] = eoscr_reg;
				scs_pkg::SCS_IDX_STATUS: rdata_next[7:0] = {2'h0, 2'(src_reg), sys_clk_reg, wdt_reg,
					cal_ran_reg, state_reg == ST_RUN};
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wait_reg <= 1'b1;
			rdata_reg <= '0;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	always_comb begin
		state_next = state_reg;
		boot_cnt_next = boot_cnt_reg;
		cal_opt_next = cal_opt_reg;
		prog_next = prog_reg;
		clkmd_next = clkmd_reg;
		eoscr_next = eoscr_reg;
		ihrcr_next = ihrcr_reg;
		wdt_next = wdt_reg;
		pin_in_next = pin_in_reg;
		cal_run_next = 1'b0;
		cal_ran_next = cal_ran_reg;
		mode_load = 1'b0;
		boot_done_next = boot_done_reg;
		unique case (state_reg)
			ST_CAPTURE: begin
				// straps are caught once both synchroniser stages hold them, then boot time runs
				if (boot_cnt_reg != SCS_STRAP_SETTLE) begin
					boot_cnt_next = boot_cnt_reg + scs_pkg::SCS_BOOT_CNT_W'(1);
				end else begin
					cal_opt_next = pin_sync[scs_pkg::SCS_PIN_CAL_MSB:scs_pkg::SCS_PIN_CAL_LSB];
					prog_next = pin_sync[scs_pkg::SCS_PIN_PROG];
					if (pin_sync[scs_pkg::SCS_PIN_BOOT]) begin
						boot_cnt_next = scs_pkg::SCS_BOOT_CNT_W'(BOOT_FAST_CYC); // [R14]
						clkmd_next = scs_pkg::SCS_CLKMD_RST_FAST; // [R11]
					end else begin
						boot_cnt_next = scs_pkg::SCS_BOOT_CNT_W'(BOOT_NORM_CYC); // [R14]
						clkmd_next = scs_pkg::SCS_CLKMD_RST_NORM; // [R11]
					end
					mode_load = 1'b1;
					state_next = ST_BOOT;
				end
			end
			ST_BOOT: begin
				if (boot_cnt_reg > scs_pkg::SCS_BOOT_CNT_W'(1)) begin
					boot_cnt_next = boot_cnt_reg - scs_pkg::SCS_BOOT_CNT_W'(1); // [R14]
				end else begin
					state_next = ST_RUN;
					boot_done_next = 1'b1;
					pin_in_next = 1'b1; // [R10] [R12]
					if (cal_opt_reg != scs_pkg::SCS_CAL_OFF) begin
						clkmd_next = scs_pkg::scs_cal_clkmd(cal_opt_reg); // [R10]
						clkmd_next[scs_pkg::SCS_CLKMD_SLOW_EN] = 1'b1; // [R2]
						wdt_next = 1'b0; // [R10]
						mode_load = 1'b1;
						// trim sequence only while the program memory is written
						if (prog_reg && !cal_ran_reg) begin
							cal_run_next = 1'b1; // [R13]
							cal_ran_next = 1'b1; // [R13]
						end
					end else begin
						wdt_next = 1'b1; // [R12]
						clkmd_next[scs_pkg::SCS_CLKMD_SLOW_EN] = 1'b1; // [R12]
					end
				end
			end
			ST_RUN: begin
				// writes before boot completes are answered but dropped
				if (wr_take) begin
					unique case (bus_idx)
						scs_pkg::SCS_IDX_CLKMD: begin
							clkmd_next = avs_writedata_i[7:0]; // [R1] [R15]
							mode_load = 1'b1; // [R15]
						end
						scs_pkg::SCS_IDX_IHRCR: ihrcr_next = avs_writedata_i[7:0]; // [R3]
						scs_pkg::SCS_IDX_EOSCR: eoscr_next = avs_writedata_i[7:0]; // [R1] [R17]
						default: ;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= ST_CAPTURE;
			boot_cnt_reg <= '0;
			cal_opt_reg <= scs_pkg::SCS_CAL_OFF;
			prog_reg <= 1'b0;
			clkmd_reg <= scs_pkg::SCS_CLKMD_RST_NORM;
			eoscr_reg <= scs_pkg::SCS_EOSCR_RST;
			ihrcr_reg <= scs_pkg::SCS_IHRCR_RST;
			wdt_reg <= 1'b1;
			pin_in_reg <= 1'b1;
			cal_run_reg <= 1'b0;
			cal_ran_reg <= 1'b0;
			boot_done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			boot_cnt_reg <= boot_cnt_next;
			cal_opt_reg <= cal_opt_next;
			prog_reg <= prog_next;
			clkmd_reg <= clkmd_next;
			eoscr_reg <= eoscr_next;
			ihrcr_reg <= ihrcr_next;
			wdt_reg <= wdt_next;
			pin_in_reg <= pin_in_next;
			cal_run_reg <= cal_run_next;
			cal_ran_reg <= cal_ran_next;
			boot_done_reg <= boot_done_next;
		end
	end

	// a disabled source gives no edges, so the system clock stalls; that is the hang
	// software must avoid by switching before disabling
	always_comb begin
		unique case (src_reg)
			scs_pkg::SCS_SRC_FAST: src_tick = osc_rise[scs_pkg::SCS_PIN_FAST] &&
				clkmd_reg[scs_pkg::SCS_CLKMD_FAST_EN];
			scs_pkg::SCS_SRC_SLOW: src_tick = (osc_rise[scs_pkg::SCS_PIN_SLOW] || osc_fall[scs_pkg::SCS_PIN_SLOW]) &&
				clkmd_reg[scs_pkg::SCS_CLKMD_SLOW_EN];
			scs_pkg::SCS_SRC_XTAL: src_tick = (osc_rise[scs_pkg::SCS_PIN_XTAL] || osc_fall[scs_pkg::SCS_PIN_XTAL]) &&
				eoscr_reg[scs_pkg::SCS_EOSCR_EN];
			default: src_tick = 1'b0;
		endcase
	end

	always_comb begin
		src_next = src_reg;
		half_next = half_reg;
		cnt_next = cnt_reg;
		sys_clk_next = sys_clk_reg;
		sys_tick_next = 1'b0;
		if (mode_load) begin
			// new source takes over at once; the divider count restarts, so the running phase lasts until
			// the new source has given a full half count of ticks, the first of which may come one cycle later
			src_next = scs_pkg::scs_mode_src(clkmd_next); // [R4] [R5] [R6] [R7] [R8] [R9] [R15]
			half_next = scs_pkg::scs_mode_half(clkmd_next); // [R4] [R5] [R6] [R7] [R8]
			cnt_next = '0; // [R18]
		end else if (src_tick) begin
			if (cnt_reg == half_reg - SCS_ONE) begin
				cnt_next = '0;
				sys_clk_next = !sys_clk_reg; // [R18]
				sys_tick_next = !sys_clk_reg;
			end else begin
				cnt_next = cnt_reg + SCS_ONE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			src_reg <= scs_pkg::SCS_SRC_SLOW;
			half_reg <= scs_pkg::SCS_HALF_1;
			cnt_reg <= '0;
			sys_clk_reg <= 1'b0;
			sys_tick_reg <= 1'b0;
		end else begin
			src_reg <= src_next;
			half_reg <= half_next;
			cnt_reg <= cnt_next;
			sys_clk_reg <= sys_clk_next;
			sys_tick_reg <= sys_tick_next;
		end
	end

	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign sys_clk_o = sys_clk_reg;
	assign sys_tick_o = sys_tick_reg;
	assign fast_rc_en_o = clkmd_reg[scs_pkg::SCS_CLKMD_FAST_EN]; // [R1]
	assign slow_rc_en_o = clkmd_reg[scs_pkg::SCS_CLKMD_SLOW_EN]; // [R1]
	assign xtal_en_o = eoscr_reg[scs_pkg::SCS_EOSCR_EN]; // [R1]
	assign xtal_drive_o = eoscr_reg[scs_pkg::SCS_EOSCR_DRV_MSB:scs_pkg::SCS_EOSCR_DRV_LSB]; // [R17]
	assign fast_rc_trim_o = ihrcr_reg; // [R3]
	assign wdt_en_o = wdt_reg;
	assign port_a_bit_five_input_o = pin_in_reg;
	assign boot_done_o = boot_done_reg;
	assign cal_run_o = cal_run_reg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	sequence s_mode_write(logic [7:0] v);
		state_reg == ST_RUN && wr_take && bus_idx == scs_pkg::SCS_IDX_CLKMD && avs_writedata_i[7:0] == v;
	endsequence

	sequence s_boot_end;
		state_reg == ST_BOOT && state_next == ST_RUN;
	endsequence

	chk_div2_select: assert property (s_mode_write(scs_pkg::SCS_CLKMD_DIV2) |=> fast_rc_en_o && // [R4]
		src_reg == scs_pkg::SCS_SRC_FAST && half_reg == scs_pkg::SCS_HALF_1) else $error("divide by two wrong");
	chk_div4_select: assert property (s_mode_write(scs_pkg::SCS_CLKMD_DIV4) |=> // [R5]
		src_reg == scs_pkg::SCS_SRC_FAST && half_reg == scs_pkg::SCS_HALF_2) else $error("divide by four wrong");
	chk_div8_select: assert property (s_mode_write(scs_pkg::SCS_CLKMD_DIV8) |=> // [R6]
		src_reg == scs_pkg::SCS_SRC_FAST && half_reg == scs_pkg::SCS_HALF_4) else $error("divide by eight wrong");
	chk_div16_select: assert property (s_mode_write(scs_pkg::SCS_CLKMD_DIV16) |=> // [R7]
		half_reg == scs_pkg::SCS_HALF_8 && cnt_reg == '0) else $error("divide by sixteen wrong");
	chk_div32_select: assert property (s_mode_write(scs_pkg::SCS_CLKMD_DIV32) |=> // [R8]
		half_reg == scs_pkg::SCS_HALF_16 ##1 !$changed(half_reg)) else $error("divide by thirty-two wrong");
	chk_slow_select: assert property (s_mode_write(scs_pkg::SCS_CLKMD_SLOW) |=> // [R9]
		src_reg == scs_pkg::SCS_SRC_SLOW && !fast_rc_en_o) else $error("slow source not selected or fast rc on");
	chk_cal_boot: assert property (s_boot_end ##0 (cal_opt_reg != scs_pkg::SCS_CAL_OFF) |=> // [R10]
		!wdt_en_o && slow_rc_en_o && port_a_bit_five_input_o && boot_done_o) else $error("calibrated boot state wrong");
	chk_nocal_boot: assert property (s_boot_end ##0 (cal_opt_reg == scs_pkg::SCS_CAL_OFF) |=> // [R12]
		wdt_en_o && slow_rc_en_o && port_a_bit_five_input_o && !cal_run_o) else $error("uncalibrated boot state wrong");
	chk_cal_once: assert property (cal_run_o |-> cal_ran_reg ##1 (!cal_run_o)[*8]) // [R13]
		else $error("calibration ran more than once");
	chk_drive_high: assert property (state_reg == ST_RUN && wr_take && bus_idx == scs_pkg::SCS_IDX_EOSCR && // [R17]
		avs_writedata_i[7:5] == 3'h7 |=> xtal_drive_o == scs_pkg::SCS_DRV_HIGH && xtal_en_o)
		else $error("crystal drive not high");
	chk_no_short_phase: assert property ($rose(sys_clk_o) |-> sys_clk_o [*2]) // [R18]
		else $error("system clock high phase too short");
endmodule : scs_clock_select

// File: scs_pkg.sv
// package: constants, register map and decode helpers for the system clock select block
package scs_pkg;
	localparam int SCS_CLK_MHZ = 200;
	localparam int SCS_BOOT_FAST_US = 750;
	localparam int SCS_BOOT_NORM_MS = 50;
	localparam int SCS_BOOT_FAST_CYC = SCS_BOOT_FAST_US * SCS_CLK_MHZ;
	localparam int SCS_BOOT_NORM_CYC = SCS_BOOT_NORM_MS * 1000 * SCS_CLK_MHZ;
	localparam int SCS_BOOT_CNT_W = 24;

	localparam logic [5:0] SCS_IDX_CLKMD = 6'h01;
	localparam logic [5:0] SCS_IDX_IHRCR = 6'h02;
	localparam logic [5:0] SCS_IDX_STATUS = 6'h04;
	localparam logic [5:0] SCS_IDX_EOSCR = 6'h0A;

	localparam int SCS_CLKMD_FAST_EN = 4;
	localparam int SCS_CLKMD_SLOW_EN = 2;
	localparam int SCS_EOSCR_EN = 7;
	localparam int SCS_EOSCR_DRV_LSB = 5;
	localparam int SCS_EOSCR_DRV_MSB = 6;

	localparam logic [7:0] SCS_CLKMD_DIV2 = 8'h34;
	localparam logic [7:0] SCS_CLKMD_DIV4 = 8'h14;
	localparam logic [7:0] SCS_CLKMD_DIV8 = 8'h3C;
	localparam logic [7:0] SCS_CLKMD_DIV16 = 8'h1C;
	localparam logic [7:0] SCS_CLKMD_DIV32 = 8'h7C;
	localparam logic [7:0] SCS_CLKMD_SLOW = 8'hE4;
	localparam logic [7:0] SCS_CLKMD_RST_FAST = 8'h74;
	localparam logic [7:0] SCS_CLKMD_RST_NORM = 8'hE4;
	localparam logic [7:0] SCS_IHRCR_RST = 8'h80;
	localparam logic [7:0] SCS_EOSCR_RST = 8'h00;

	localparam logic [1:0] SCS_DRV_LOW = 2'h1;
	localparam logic [1:0] SCS_DRV_MID = 2'h2;
	localparam logic [1:0] SCS_DRV_HIGH = 2'h3;

	localparam logic [2:0] SCS_CAL_OFF = 3'h0;
	localparam logic [2:0] SCS_CAL_DIV2 = 3'h1;
	localparam logic [2:0] SCS_CAL_DIV4 = 3'h2;
	localparam logic [2:0] SCS_CAL_DIV8 = 3'h3;
	localparam logic [2:0] SCS_CAL_DIV16 = 3'h4;
	localparam logic [2:0] SCS_CAL_DIV32 = 3'h5;

	localparam int SCS_HALF_W = 6;
	localparam logic [5:0] SCS_HALF_1 = 6'h01;
	localparam logic [5:0] SCS_HALF_2 = 6'h02;
	localparam logic [5:0] SCS_HALF_4 = 6'h04;
	localparam logic [5:0] SCS_HALF_8 = 6'h08;
	localparam logic [5:0] SCS_HALF_16 = 6'h10;
	localparam logic [5:0] SCS_HALF_32 = 6'h20;

	localparam int SCS_SYNC_W = 8;
	localparam int SCS_PIN_FAST = 0;
	localparam int SCS_PIN_SLOW = 1;
	localparam int SCS_PIN_XTAL = 2;
	localparam int SCS_PIN_BOOT = 3;
	localparam int SCS_PIN_CAL_LSB = 4;
	localparam int SCS_PIN_CAL_MSB = 6;
	localparam int SCS_PIN_PROG = 7;

	typedef enum logic [1:0] {SCS_SRC_FAST, SCS_SRC_SLOW, SCS_SRC_XTAL} scs_src_t;

	function automatic scs_src_t scs_mode_src(input logic [7:0] m);
		if (!m[7]) begin
			return SCS_SRC_FAST;
		end
		return (m[6] || !m[5]) ? SCS_SRC_SLOW : SCS_SRC_XTAL;
	endfunction : scs_mode_src

	// half period of the fast rc divider, in fast rc rising edges
	function automatic logic [5:0] scs_mode_half(input logic [7:0] m);
		logic [2:0] key;
		key = {m[6:5], m[3]};
		if (m[7]) begin
			return SCS_HALF_1;
		end
		unique case (key)
			3'h2: return SCS_HALF_1;
			3'h0: return SCS_HALF_2;
			3'h3: return SCS_HALF_4;
			3'h1: return SCS_HALF_8;
			3'h7: return SCS_HALF_16;
			default: return SCS_HALF_32;
		endcase
	endfunction : scs_mode_half

	function automatic logic [7:0] scs_cal_clkmd(input logic [2:0] opt);
		unique case (opt)
			SCS_CAL_DIV2: return SCS_CLKMD_DIV2;
			SCS_CAL_DIV4: return SCS_CLKMD_DIV4;
			SCS_CAL_DIV8: return SCS_CLKMD_DIV8;
			SCS_CAL_DIV16: return SCS_CLKMD_DIV16;
			SCS_CAL_DIV32: return SCS_CLKMD_DIV32;
			default: return SCS_CLKMD_SLOW;
		endcase
	endfunction : scs_cal_clkmd
endpackage : scs_pkg

// File: scs_sync.sv
// two flip-flop synchroniser for the oscillator and strap pins
`timescale 1ns/1ps
module scs_sync #(
	parameter int WIDTH = scs_pkg::SCS_SYNC_W
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// meta_reg feeds sync_reg only
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule : scs_sync

// File: system_clock_select_test.sv
// self-checking bench for the system clock select block
`timescale 1ns/1ps
module system_clock_select_test;
	// shortened boot counts keep the run small
	localparam int BF = 20;
	localparam int BN = 40;
	localparam logic [7:0] CAL_MD [1:7] = '{8'h34, 8'h14, 8'h3C, 8'h1C, 8'h7C, 8'hE4, 8'hE4};
	localparam int CAL_PER [1:7] = '{4, 8, 16, 32, 64, 16, 16};
	localparam logic [7:0] MD [0:4] = '{8'h14, 8'h3C, 8'h1C, 8'h7C, 8'h34};
	localparam int PER [0:4] = '{8, 16, 32, 64, 4};
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic fast_osc = 1'b0;
	logic slow_osc = 1'b0;
	logic xtal_osc = 1'b0;
	logic boot_fast = 1'b0;
	logic [2:0] cal_opt = 3'h0;
	logic prog = 1'b0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, sys_clk_o, sys_tick_o, fast_rc_en_o, slow_rc_en_o, xtal_en_o;
	logic [1:0] xtal_drive_o;
	logic [7:0] fast_rc_trim_o;
	logic wdt_en_o, port_a_bit_five_input_o, boot_done_o, cal_run_o;
	logic last_clk = 1'b0;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	int rel = 0;
	int run = 0;
	int n_cal = 0;

	scs_clock_select #(.BOOT_FAST_CYC(BF), .BOOT_NORM_CYC(BN)) scs_clock_select_inst (
		.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.fast_internal_rc_osc_i(fast_osc), .slow_internal_rc_osc_i(slow_osc),
		.external_crystal_osc_i(xtal_osc), .boot_fast_i(boot_fast), .calibration_directive_i(cal_opt),
		.prog_mode_i(prog), .sys_clk_o(sys_clk_o), .sys_tick_o(sys_tick_o), .fast_rc_en_o(fast_rc_en_o),
		.slow_rc_en_o(slow_rc_en_o), .xtal_en_o(xtal_en_o), .xtal_drive_o(xtal_drive_o),
		.fast_rc_trim_o(fast_rc_trim_o), .wdt_en_o(wdt_en_o),
		.port_a_bit_five_input_o(port_a_bit_five_input_o), .boot_done_o(boot_done_o), .cal_run_o(cal_run_o));

	always #2.5 clk_i = ~clk_i;

	// fast rc period 2 cycles, crystal 8, slow 16
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		fast_osc <= ~fast_osc;
		if (cyc % 4 == 3) xtal_osc <= ~xtal_osc;
		if (cyc % 8 == 7) slow_osc <= ~slow_osc;
	end

	// shortest legal phase is the /2 half period of two cycles
	always @(negedge clk_i) begin
		if (cal_run_o === 1'b1) n_cal++;
		if (sys_clk_o !== last_clk) begin
			if (boot_done_o === 1'b1 && !srst_i && run < 2) cmp_cnt(run, 2);
			run = 1;
		end else begin
			run++;
		end
		last_clk = sys_clk_o;
	end

	task automatic end_sim();
		$display("errors=%0d compared=%0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic fail_to();
		error_cnt++;
		end_sim();
	endtask : fail_to

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_flag(input logic got, input logic exp);
		cmp_reg({31'h0, got}, {31'h0, exp});
	endtask : cmp_flag

	task automatic cmp_cnt(input int got, input int exp);
		cmp_reg(got, exp);
	endtask : cmp_cnt

	// one avalon access; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
			output logic [31:0] q);
		int i;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		if (wr) avs_write_i <= 1'b1;
		else avs_read_i <= 1'b1;
		// waitrequest and read data are sampled at the rising edge itself
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		if (i == 20) fail_to();
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h0, d}, 4'hF, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hF, q);
		cmp_reg(q, exp);
	endtask : rd_chk

	task automatic reset_dut(input logic f, input logic [2:0] c, input logic p);
		@(posedge clk_i);
		srst_i <= 1'b1;
		boot_fast <= f;
		cal_opt <= c;
		prog <= p;
		repeat (12) @(posedge clk_i);
		srst_i <= 1'b0;
		rel = cyc;
		n_cal = 0;
	endtask : reset_dut

	// boot end must land a few cycles after the chosen count
	task automatic wait_boot(input int n);
		int i;
		for (i = 0; i < 400; i++) begin
			@(negedge clk_i);
			if (boot_done_o === 1'b1) break;
		end
		if (i == 400) fail_to();
		cmp_flag(cyc - rel >= n && cyc - rel <= n + 5, 1'b1);
	endtask : wait_boot

	task automatic outs(input logic f, input logic w);
		cmp_flag(fast_rc_en_o, f);
		cmp_flag(slow_rc_en_o, 1'b1);
		cmp_flag(wdt_en_o, w);
		cmp_flag(port_a_bit_five_input_o, 1'b1);
	endtask : outs

	// skips two ticks so a fresh mode has settled, then times one period
	task automatic period(input int exp);
		int i;
		int t0;
		t0 = 0;
		for (int k = 0; k < 4; k++) begin
			for (i = 0; i < 600; i++) begin
				@(negedge clk_i);
				if (sys_tick_o === 1'b1) break;
			end
			if (i == 600) fail_to();
			if (k == 2) t0 = cyc;
		end
		cmp_cnt(cyc - t0, exp);
	endtask : period

	initial begin
		logic [31:0] q;
		reset_dut(1'b0, 3'h0, 1'b0);
		rd_chk(8'h04, 32'hE4);
		wr(8'h08, 8'h11);
		wait_boot(BN);
		rd_chk(8'h08, 32'h80);
		rd_chk(8'h04, 32'hE4);
		outs(1'b0, 1'b1);
		period(16);
		cmp_cnt(n_cal, 0);
		reset_dut(1'b1, 3'h0, 1'b0);
		wait_boot(BF);
		rd_chk(8'h04, 32'h74);
		outs(1'b1, 1'b1);
		period(128);
		for (int c = 1; c < 8; c++) begin
			reset_dut(1'b0, c[2:0], 1'b1);
			wait_boot(BN);
			rd_chk(8'h04, {24'h0, CAL_MD[c]});
			outs(CAL_MD[c][4], 1'b0);
			period(CAL_PER[c]);
			cmp_cnt(n_cal, 1);
			bus(1'b0, 8'h10, 32'h0, 4'hF, q);
			cmp_reg(q & 32'h37, (c > 5) ? 32'h13 : 32'h03);
		end
		reset_dut(1'b1, 3'h1, 1'b0);
		wait_boot(BF);
		rd_chk(8'h04, 32'h34);
		cmp_cnt(n_cal, 0);
		for (int k = 0; k < 5; k++) begin
			wr(8'h04, MD[k]);
			rd_chk(8'h04, {24'h0, MD[k]});
			cmp_flag(fast_rc_en_o, 1'b1);
			period(PER[k]);
		end
		wr(8'h04, 8'hF4);
		wr(8'h04, 8'hE4);
		rd_chk(8'h04, 32'hE4);
		cmp_flag(fast_rc_en_o, 1'b0);
		period(16);
		bus(1'b1, 8'h04, 32'h34, 4'h0, q);
		rd_chk(8'h04, 32'hE4);
		wr(8'h08, 8'h5A);
		rd_chk(8'h08, 32'h5A);
		cmp_reg({24'h0, fast_rc_trim_o}, 32'h5A);
		rd_chk(8'h3C, 32'h0);
		wr(8'h10, 8'hFF);
		bus(1'b0, 8'h10, 32'h0, 4'hF, q);
		cmp_reg(q & 32'hF7, 32'h11);
		for (int d = 1; d < 4; d++) begin
			wr(8'h28, {1'b1, d[1:0], 5'h0});
			rd_chk(8'h28, {24'h0, 1'b1, d[1:0], 5'h0});
			cmp_reg({30'h0, xtal_drive_o}, d);
			cmp_flag(xtal_en_o, 1'b1);
		end
		wr(8'h04, 8'hA6);
		period(8);
		wr(8'h04, 8'hA2);
		@(negedge clk_i);
		cmp_flag(slow_rc_en_o, 1'b0);
		period(8);
		end_sim();
	end
endmodule : system_clock_select_test
